// [rtl/pced_top.sv]
// Pin change edge detector with Avalon-MM register slave
// Function
// - Enabled rising edge sets pin flag and summary flag.
// - Enabled falling edge sets pin flag and summary flag.
// - Both enables zero: pin flag never set.
// - Hardware only sets flags; it clears only port A flag bits 1 and 0, while the debugger is enabled.
// - Software clears a flag by writing 0; stays 0 until next edge.
// - Port A implements pins 5 to 0 only.
// - Port B implements pins 7 to 4 only.
// - Port C implements all pins 7 to 0.
// - Unimplemented bits read 0 and ignore writes.
// - All enable and flag bits reset to 0.
// - Debugger enabled: port A bits 1 and 0 unavailable.
// - Detection continues with change interrupt enable at 0.
// - Summary flag is OR of all pin flags.
// - Edge during flag write leaves flag set.
// - Change event raises wake when change interrupt enable set.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pced_top
   import pced_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [PCED_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [PCED_DW-1:0] avs_writedata,
   output logic [PCED_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PCED_PW-1:0] porta_pins,
   input wire logic [PCED_PW-1:0] portb_pins,
   input wire logic [PCED_PW-1:0] portc_pins,
   input wire logic [PCED_PW-1:0] porte_pins,
   input wire logic debug_enable,
   output logic change_summary_flag,
   output logic change_irq,
   output logic wake_request,
   output logic irq
);

   typedef enum logic [1:0] {
      PCED_IDLE = 2'b01,
      PCED_ACK = 2'b10
   } pced_state_t;

   pced_req_t req;
   pced_state_t state;
   pced_state_t next_state;
   logic [PCED_DW-1:0] next_readdata;
   logic [PCED_PW-1:0] pins [PCED_NPORT];
   logic [PCED_PW-1:0] impl [PCED_NPORT];
   logic [PCED_PW-1:0] sync1 [PCED_NPORT];
   logic [PCED_PW-1:0] sync2 [PCED_NPORT];
   logic [PCED_PW-1:0] prev [PCED_NPORT];
   logic [PCED_PW-1:0] edge_hit [PCED_NPORT];
   pced_port_t port [PCED_NPORT];
   pced_port_t next_port [PCED_NPORT];
   logic [PCED_AW-1:0] off_rise [PCED_NPORT];
   logic [PCED_AW-1:0] off_fall [PCED_NPORT];
   logic [PCED_AW-1:0] off_flag [PCED_NPORT];
   logic [PCED_NPORT-1:0] port_any;
   logic dbg_s1;
   logic dbg_s2;
   logic irq_en;
   logic next_irq_en;
   logic irq_stat;
   logic next_irq_stat;
   logic irq_mask;
   logic next_irq_mask;
   logic summary_q;
   logic acc_wr;
   logic acc_rd;

   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata};
   assign pins[0] = porta_pins;
   assign pins[1] = portb_pins;
   assign pins[2] = portc_pins;
   assign pins[3] = porte_pins;
   assign impl[0] = dbg_s2 ? (MASK_PA & ~MASK_PA_DBG) : MASK_PA;
   assign impl[1] = MASK_PB;
   assign impl[2] = MASK_PC;
   assign impl[3] = MASK_PE;
   assign off_rise = '{OFF_PA_RISE, OFF_PB_RISE, OFF_PC_RISE, OFF_PE_RISE};
   assign off_fall = '{OFF_PA_FALL, OFF_PB_FALL, OFF_PC_FALL, OFF_PE_FALL};
   assign off_flag = '{OFF_PA_FLAG, OFF_PB_FLAG, OFF_PC_FLAG, OFF_PE_FLAG};

   // Writes land in the ACK state; read data is captured in the IDLE cycle so that
   // it stands while waitrequest is low, and a status read clears at that capture
   assign acc_wr = (state == PCED_ACK) && req.write;
   assign acc_rd = (state == PCED_IDLE) && req.read;
   assign avs_waitrequest = (req.read || req.write) && (state != PCED_ACK);

   always_comb begin
      next_state = PCED_IDLE;
      case (state)
         PCED_IDLE: begin
            if (req.read || req.write) begin
               next_state = PCED_ACK;
            end
         end
         PCED_ACK: next_state = PCED_IDLE;
         default: next_state = PCED_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= PCED_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dbg_s1 <= 1'b0;
         dbg_s2 <= 1'b0;
      end else begin
         dbg_s1 <= debug_enable;
         dbg_s2 <= dbg_s1;
      end
   end

   generate
      for (genvar p = 0; p < PCED_NPORT; p++) begin : g_port
         // Two-stage synchroniser then previous-sample compare
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               sync1[p] <= ZERO_B;
               sync2[p] <= ZERO_B;
               prev[p] <= ZERO_B;
            end else begin
               sync1[p] <= pins[p];
               sync2[p] <= sync1[p];
               prev[p] <= sync2[p];
            end
         end

         assign edge_hit[p] = impl[p] & ((port[p].rise & sync2[p] & ~prev[p])
                              | (port[p].fall & ~sync2[p] & prev[p]));

         always_comb begin
            next_port[p] = port[p];
            if (acc_wr && req.address == off_rise[p]) begin
               next_port[p].rise = req.writedata[PCED_PW-1:0] & impl[p];
            end
            if (acc_wr && req.address == off_fall[p]) begin
               next_port[p].fall = req.writedata[PCED_PW-1:0] & impl[p];
            end
            if (acc_wr && req.address == off_flag[p]) begin
               next_port[p].flag = port[p].flag & req.writedata[PCED_PW-1:0];
            end
            next_port[p].flag = (next_port[p].flag | edge_hit[p]) & impl[p];
         end

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               port[p] <= '{rise: ZERO_B, fall: ZERO_B, flag: ZERO_B};
            end else begin
               port[p] <= next_port[p];
            end
         end

         assign port_any[p] = |(port[p].flag & impl[p]);
      end
   endgenerate

   assign summary_q = |port_any;

   always_comb begin
      next_irq_en = irq_en;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (acc_wr && req.address == OFF_CTRL) begin
         next_irq_en = req.writedata[CTRL_IRQ_EN_BIT];
      end
      if (acc_wr && req.address == OFF_IRQ_MASK) begin
         next_irq_mask = req.writedata[STAT_CHANGE_BIT];
      end
      if (acc_rd && req.address == OFF_IRQ_STAT) begin
         next_irq_stat = 1'b0;
      end
      if (|{edge_hit[0], edge_hit[1], edge_hit[2], edge_hit[3]}) begin
         next_irq_stat = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_en <= 1'b0;
         irq_mask <= 1'b0;
         irq_stat <= 1'b0;
      end else begin
         irq_en <= next_irq_en;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
      end
   end

   always_comb begin
      next_readdata = avs_readdata;
      if (acc_rd) begin
         next_readdata = UNMAPPED_W;
         for (int i = 0; i < PCED_NPORT; i++) begin
            if (req.address == off_rise[i]) begin
               next_readdata = {24'h00_0000, port[i].rise & impl[i]};
            end
            if (req.address == off_fall[i]) begin
               next_readdata = {24'h00_0000, port[i].fall & impl[i]};
            end
            if (req.address == off_flag[i]) begin
               next_readdata = {24'h00_0000, port[i].flag & impl[i]};
            end
         end
         if (req.address == OFF_CTRL) begin
            next_readdata = {31'h0000_0000, irq_en};
         end
         if (req.address == OFF_IRQ_STAT) begin
            next_readdata = {31'h0000_0000, irq_stat};
         end
         if (req.address == OFF_IRQ_MASK) begin
            next_readdata = {31'h0000_0000, irq_mask};
         end
      end
   end

   // Read data is registered at the end of the wait cycle and stands until the next read
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_readdata <= ZERO_W;
      end else begin
         avs_readdata <= next_readdata;
      end
   end

   assign change_summary_flag = summary_q;
   assign change_irq = summary_q & irq_en;
   assign wake_request = summary_q & irq_en;
   assign irq = irq_stat & irq_mask;

   a_rise_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (port[2].rise[0] && sync2[2][0] && !prev[2][0]) |=> port[2].flag[0])
      else $error("rising edge did not set flag");

   a_fall_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (port[2].fall[3] && !sync2[2][3] && prev[2][3]) |=> port[2].flag[3])
      else $error("falling edge did not set flag");

   a_disabled_no_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!port[2].rise[1] && !port[2].fall[1] && !port[2].flag[1]
       && !(acc_wr && req.address == OFF_PC_FLAG)) |=> !port[2].flag[1])
      else $error("flag set with both enables clear");

   a_hw_no_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (port[2].flag[5] && !(acc_wr && req.address == OFF_PC_FLAG)) |=> port[2].flag[5])
      else $error("flag cleared without write");

   a_write_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (acc_wr && req.address == OFF_PC_FLAG && !req.writedata[2] && !edge_hit[2][2])
      |=> !port[2].flag[2])
      else $error("write of zero did not clear flag");

   a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ((port[0].rise | port[0].fall | port[0].flag) & ~MASK_PA) == ZERO_B
      && ((port[1].flag | port[1].rise) & ~MASK_PB) == ZERO_B
      && ((port[3].flag | port[3].fall) & ~MASK_PE) == ZERO_B)
      else $error("unimplemented bit set");

   a_summary_or: assert property (@(posedge ref_clk) disable iff (sys_rst)
      change_summary_flag == |(port[0].flag | port[1].flag | port[2].flag | port[3].flag))
      else $error("summary flag mismatch");

   a_edge_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (acc_wr && req.address == OFF_PC_FLAG && edge_hit[2][4]) |=> port[2].flag[4])
      else $error("edge lost during flag write");

   a_debug_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
      dbg_s2 |=> (port[0].flag & MASK_PA_DBG) == ZERO_B)
      else $error("debugger bits active");

   a_reset_clear: assert property (@(posedge ref_clk)
      sys_rst |=> (port[2].rise == ZERO_B && port[2].flag == ZERO_B && !irq))
      else $error("reset did not clear state");

   // Bus handshake in two steps: request seen in IDLE, answered one cycle later
   sequence s_bus_request;
      (state == PCED_IDLE) && (req.read || req.write) && avs_waitrequest;
   endsequence

   sequence s_bus_answer;
      (state == PCED_ACK) && !avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_bus_request |=> s_bus_answer)
      else $error("request not answered after one wait cycle");

   a_bus_idle_ready: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !(req.read || req.write) |-> !avs_waitrequest)
      else $error("waitrequest high without a request");

   a_read_upper_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == PCED_ACK && req.read) |-> avs_readdata[PCED_DW-1:PCED_PW] == 24'h00_0000)
      else $error("read data upper bits not zero");

   // Rising level on port C pin 0 walking through the synchroniser and compare stage
   sequence s_c0_sync_high;
      sync1[2][0] && !sync2[2][0];
   endsequence

   sequence s_c0_rise_seen;
      sync2[2][0] && !prev[2][0] && port[2].rise[0];
   endsequence

   a_rise_latency: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_c0_sync_high ##1 s_c0_rise_seen |=> port[2].flag[0] && change_summary_flag)
      else $error("rising edge not flagged after synchroniser");

   // Falling level on port C pin 3 walking through the same stages
   sequence s_c3_sync_low;
      !sync1[2][3] && sync2[2][3];
   endsequence

   sequence s_c3_fall_seen;
      !sync2[2][3] && prev[2][3] && port[2].fall[3];
   endsequence

   a_fall_latency: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_c3_sync_low ##1 s_c3_fall_seen |=> port[2].flag[3] && change_summary_flag)
      else $error("falling edge not flagged after synchroniser");

   a_single_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sync2[2][5] && !prev[2][5]) |=> !(sync2[2][5] && !prev[2][5]))
      else $error("one rising level seen as two edges");

   a_no_soft_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!port[2].flag[6] && !edge_hit[2][6]) |=> !port[2].flag[6])
      else $error("flag set without an enabled edge");

   a_debug_no_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
      dbg_s2 |-> (edge_hit[0] & MASK_PA_DBG) == ZERO_B)
      else $error("edge on a debugger pin while the debugger holds it");

   a_detect_irq_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!irq_en && edge_hit[2][7] && !(acc_wr && req.address == OFF_CTRL))
      |=> port[2].flag[7] && !change_irq)
      else $error("detection blocked or interrupt raised while disabled");

   a_wake_on_change: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (irq_en && change_summary_flag) |-> wake_request && change_irq)
      else $error("change with interrupt enabled did not raise wake");

   a_stat_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (|{edge_hit[0], edge_hit[1], edge_hit[2], edge_hit[3]}) |=> irq_stat)
      else $error("edge event lost from status");

   a_stat_read_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (acc_rd && req.address == OFF_IRQ_STAT
       && !(|{edge_hit[0], edge_hit[1], edge_hit[2], edge_hit[3]})) |=> !irq_stat)
      else $error("status read did not clear");

   a_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
      irq == (irq_stat && irq_mask))
      else $error("interrupt output not status and mask");

   a_write_one_keeps: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (acc_wr && req.address == OFF_PC_FLAG && req.writedata[5] && port[2].flag[5])
      |=> port[2].flag[5])
      else $error("writing one cleared a flag");

   a_port_e_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (port[3].rise & ~MASK_PE) == ZERO_B)
      else $error("port E upper enable bit set");

endmodule : pced_top
`default_nettype wire

// [include/pced_pkg.sv]
// Package for the pin change edge detector: register map, field masks, bus types
package pced_pkg;

   localparam int PCED_AW = 6;
   localparam int PCED_DW = 32;
   localparam int PCED_PW = 8;
   localparam int PCED_NPORT = 4;

   // Register byte offsets
   localparam logic [PCED_AW-1:0] OFF_PA_RISE = 6'h00;
   localparam logic [PCED_AW-1:0] OFF_PA_FALL = 6'h04;
   localparam logic [PCED_AW-1:0] OFF_PA_FLAG = 6'h08;
   localparam logic [PCED_AW-1:0] OFF_PB_RISE = 6'h0c;
   localparam logic [PCED_AW-1:0] OFF_PB_FALL = 6'h10;
   localparam logic [PCED_AW-1:0] OFF_PB_FLAG = 6'h14;
   localparam logic [PCED_AW-1:0] OFF_PC_RISE = 6'h18;
   localparam logic [PCED_AW-1:0] OFF_PC_FALL = 6'h1c;
   localparam logic [PCED_AW-1:0] OFF_PC_FLAG = 6'h20;
   localparam logic [PCED_AW-1:0] OFF_PE_RISE = 6'h24;
   localparam logic [PCED_AW-1:0] OFF_PE_FALL = 6'h28;
   localparam logic [PCED_AW-1:0] OFF_PE_FLAG = 6'h2c;
   localparam logic [PCED_AW-1:0] OFF_CTRL = 6'h30;
   localparam logic [PCED_AW-1:0] OFF_IRQ_STAT = 6'h34;
   localparam logic [PCED_AW-1:0] OFF_IRQ_MASK = 6'h38;

   // Implemented bit masks per port (A, B, C, E)
   localparam logic [PCED_PW-1:0] MASK_PA = 8'h3f;
   localparam logic [PCED_PW-1:0] MASK_PB = 8'hf0;
   localparam logic [PCED_PW-1:0] MASK_PC = 8'hff;
   localparam logic [PCED_PW-1:0] MASK_PE = 8'h0f;
   // Port A bits held by the debugger
   localparam logic [PCED_PW-1:0] MASK_PA_DBG = 8'h03;

   localparam logic [PCED_PW-1:0] ZERO_B = 8'h00;
   localparam logic [PCED_DW-1:0] ZERO_W = 32'h0000_0000;
   localparam logic [PCED_DW-1:0] UNMAPPED_W = 32'h0000_0000;

   // Control register field
   localparam int CTRL_IRQ_EN_BIT = 0;
   // Interrupt status field
   localparam int STAT_CHANGE_BIT = 0;

   typedef struct packed {
      logic read;
      logic write;
      logic [PCED_AW-1:0] address;
      logic [PCED_DW-1:0] writedata;
   } pced_req_t;

   typedef struct packed {
      logic [PCED_PW-1:0] rise;
      logic [PCED_PW-1:0] fall;
      logic [PCED_PW-1:0] flag;
   } pced_port_t;

endpackage : pced_pkg

// [tb/pced_pin_model.sv]
// External pin source for the four ports
`timescale 1ns/1ps
`default_nettype none
module pced_pin_model (
   input wire logic ref_clk,
   output logic [31:0] pins
);
   initial pins = 32'h0000_0000;
   // Levels change just after a clock edge and then hold
   task automatic drive(input logic [31:0] v);
      @(posedge ref_clk);
      pins <= v;
   endtask : drive
endmodule : pced_pin_model
`default_nettype wire

// [tb/pced_top_tb_top.sv]
// Self-checking bench for the pin change edge detector
`timescale 1ns/1ps
`default_nettype none
module pced_top_tb_top;
   import pced_pkg::*;
   logic ref_clk, sys_rst, avs_read, avs_write, debug_enable;
   logic [PCED_AW-1:0] avs_address;
   logic [PCED_DW-1:0] avs_writedata, avs_readdata, q;
   logic avs_waitrequest, sum_flag, chg_irq, wake, irq, m_stat;
   wire [31:0] pin_bus;
   logic [7:0] m_rise[4], m_fall[4], m_flag[4], m_pin[4], msk[4];
   int n_mismatch = 0, checks_done = 0, cyc = 0, seed, p, i;

   pced_top u_pced_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .porta_pins(pin_bus[7:0]), .portb_pins(pin_bus[15:8]), .portc_pins(pin_bus[23:16]),
      .porte_pins(pin_bus[31:24]), .debug_enable(debug_enable),
      .change_summary_flag(sum_flag), .change_irq(chg_irq), .wake_request(wake), .irq(irq));
   pced_pin_model u_pced_pin_model (.ref_clk(ref_clk), .pins(pin_bus));

   task automatic wrap_up();
      $display("Counts: checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input int a, input logic [31:0] d);
      avs_address <= PCED_AW'(a);
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic rd(input int a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(q, e);
   endtask : rd

   task automatic wr(input int a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   function automatic logic anyf();
      logic s;
      s = 1'b0;
      for (int k = 0; k < 4; k++) s |= |(m_flag[k] & msk[k]);
      return s;
   endfunction : anyf

   // Model: enabled edges set flags and the sticky event bit
   task automatic pins(input logic [31:0] v);
      logic [7:0] nv, hit;
      for (int k = 0; k < 4; k++) begin
         nv = v[8*k +: 8];
         hit = ((nv & ~m_pin[k] & m_rise[k]) | (~nv & m_pin[k] & m_fall[k])) & msk[k];
         m_flag[k] |= hit;
         if (hit != 8'h0) m_stat = 1'b1;
         m_pin[k] = nv;
      end
      u_pced_pin_model.drive(v);
      repeat (6) @(posedge ref_clk);
   endtask : pins

   task automatic flags();
      for (int k = 0; k < 4; k++) rd(12*k+8, {24'h0, m_flag[k] & msk[k]});
      check({31'h0, sum_flag}, {31'h0, anyf()});
   endtask : flags

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      seed = 20;
      {sys_rst, avs_read, avs_write, debug_enable} = 4'b1000;
      avs_address = '0;
      avs_writedata = '0;
      m_stat = 1'b0;
      msk = '{MASK_PA, MASK_PB, MASK_PC, MASK_PE};
      m_rise = '{default: 8'h00};
      m_fall = '{default: 8'h00};
      m_flag = '{default: 8'h00};
      m_pin = '{default: 8'h00};
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (p = 0; p < 15; p++) rd(4*p, 32'h0);
      rd(60, 32'h0);
      $display("Test reset values done");
      for (p = 0; p < 4; p++) begin
         wr(12*p, 32'hffff_ffff);
         wr(12*p+4, 32'hffff_ffff);
         wr(12*p+8, 32'hffff_ffff);
         rd(12*p, {24'h0, msk[p]});
         rd(12*p+4, {24'h0, msk[p]});
         rd(12*p+8, 32'h0);
      end
      $display("Test implemented bits done");
      for (i = 0; i < 16; i++) begin
         if (i % 4 == 0) begin
            for (p = 0; p < 4; p++) begin
               m_rise[p] = 8'($random(seed)) & msk[p];
               m_fall[p] = 8'($random(seed)) & msk[p];
               wr(12*p, {24'h0, m_rise[p]});
               wr(12*p+4, {24'h0, m_fall[p]});
            end
         end
         pins($random(seed));
         flags();
         check({31'h0, chg_irq}, 32'h0);
         p = $random(seed) & 3;
         q = $random(seed);
         m_flag[p] &= q[7:0];
         wr(12*p+8, q);
      end
      flags();
      $display("Test random edges done");
      m_rise[2] = 8'hff;
      m_fall[2] = 8'hff;
      wr(24, 32'hff);
      wr(28, 32'hff);
      pins({m_pin[3], ~m_pin[2], m_pin[1], m_pin[0]});
      wr(48, 32'h1);
      check({30'h0, chg_irq, wake}, {30'h0, {2{anyf()}}});
      wr(56, 32'h1);
      check({31'h0, irq}, {31'h0, m_stat});
      rd(52, {31'h0, m_stat});
      m_stat = 1'b0;
      check({31'h0, irq}, 32'h0);
      wr(56, 32'h0);
      pins({m_pin[3], ~m_pin[2], m_pin[1], m_pin[0]});
      check({31'h0, irq}, 32'h0);
      rd(52, 32'h1);
      m_pin[2] ^= 8'h10;
      m_flag[2] = 8'h10;
      u_pced_pin_model.drive({m_pin[3], m_pin[2], m_pin[1], m_pin[0]});
      @(posedge ref_clk);
      wr(32, 32'h0);
      repeat (4) @(posedge ref_clk);
      flags();
      $display("Test interrupt done");
      debug_enable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      msk[0] = MASK_PA & ~MASK_PA_DBG;
      m_rise[0] = msk[0];
      m_fall[0] = msk[0];
      wr(0, 32'hff);
      wr(4, 32'hff);
      rd(0, {24'h0, msk[0]});
      pins({m_pin[3], m_pin[2], m_pin[1], ~m_pin[0]});
      flags();
      $display("Test debugger mask done");
      wrap_up();
   end
endmodule : pced_top_tb_top
`default_nettype wire
